// ===== include/dsrs_if.sv
`default_nettype none
interface dsrs_if;
  logic       cke;
  logic [3:0] cmd;
  logic       odt;
  logic       reset_n;
  logic       clk_run;
  logic [7:0] mr2;
  modport ctl (output cke, output cmd, output odt, output reset_n, output clk_run,
               output mr2);
  modport dev (input cke, input cmd, input odt, input reset_n, input clk_run, input mr2);
endinterface
`default_nettype wire

// ===== include/dsrs_pkg.sv
`default_nettype none
package dsrs_pkg;
  // Command encodings on {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_ZQCL    = 4'h6;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [3:0] CMD_READ    = 4'h5;
  localparam logic [3:0] CMD_DES     = 4'h8;
  // Mode register 2 field positions.
  localparam int MR2_AUTO_BIT  = 6;
  localparam int MR2_RANGE_BIT = 7;
  // Timing counts in clock cycles.
  localparam int CNT_W            = 12;
  localparam logic [11:0] VREF_WRITE_WAIT = 12'h200;
  localparam logic [11:0] DEF_CKESR  = 12'h005;
  localparam logic [11:0] DEF_CKSRE  = 12'h005;
  localparam logic [11:0] DEF_CKSRX  = 12'h005;
  localparam logic [11:0] DEF_XS     = 12'h010;
  localparam logic [11:0] DEF_XSDLL  = 12'h200;
  localparam logic [11:0] DEF_ZQOPER = 12'h100;
  localparam logic [11:0] CKE_PERIOD = 12'h003;
  // Software register offsets of the controller.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_CKESR  = 4'h2;
  localparam logic [3:0] REG_CKSRE  = 4'h3;
  localparam logic [3:0] REG_CKSRX  = 4'h4;
  localparam logic [3:0] REG_XS     = 4'h5;
  localparam logic [3:0] REG_XSDLL  = 4'h6;
  localparam logic [3:0] REG_ZQOPER = 4'h7;
  // Control register bit positions.
  localparam int CTRL_ENTER    = 0;
  localparam int CTRL_EXIT     = 1;
  localparam int CTRL_STOPCLK  = 2;
  localparam int CTRL_AUTO     = 3;
  localparam int CTRL_RANGE    = 4;
  localparam int CTRL_HOT      = 5;
  localparam int CTRL_VFLOAT   = 6;
  localparam int CTRL_ODT_USED = 7;
  localparam int CTRL_WRITE    = 8;
  localparam int CTRL_LOCKED   = 9;
  typedef enum logic [2:0] {
    DSRS_C_IDLE  = 3'b000,
    DSRS_C_ENTER = 3'b001,
    DSRS_C_IN    = 3'b010,
    DSRS_C_XS    = 3'b011,
    DSRS_C_ZQ    = 3'b100,
    DSRS_C_READY = 3'b101
  } dsrs_ctl_state_type;
endpackage
`default_nettype wire

// ===== rtl/dsrs_ctl.sv
// Contract
// - Entry is REFRESH with CKE low
// - DLL off on entry, reset on exit
// - Floating reference: wait 512 before WRITE
// - Entry only when idle and precharged
// - ODT low before entry command
// - Hold CKE low during self refresh
// - Device ignores all but CKE, reset
// - Internal refresh within CKE period
// - Stable clock; exit after tCKESR (with clock stop the code waits tCKSRE and tCKSRX instead)
// - Clock change waits tCKSRE, tCKSRX
// - Only NOP/DES during tXS
// - ZQCL, tZQOPER, tXSDLL before DLL commands
// - NOP/DES after entry until exit
// - Exit intervals count from CKE high
// - Range bit selects temperature range
// - Automatic bit adjusts refresh rate
// - Never both automatic and range bits
// - Hot: double external refresh rate
// - Hot: self refresh needs auto/range
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`default_nettype none
module dsrs_ctl (
  input  wire logic        sys_clk,   // System clock, 40 MHz.
  input  wire logic        nrst,      // Asynchronous reset, active low.
  input  wire logic [3:0]  addr,      // Register address.
  input  wire logic [15:0] wdata,     // Write data.
  input  wire logic        wr,        // Write strobe.
  input  wire logic        rd,        // Read strobe.
  input  wire logic        bank_idle, // All banks precharged and no burst.
  output logic      [15:0] rdata,     // Read data, one cycle after rd.
  output logic             ref_fast,  // External refresh at 32 ms period.
  dsrs_if.ctl              link       // Pins toward the device.
);
  dsrs_pkg::dsrs_ctl_state_type state;
  logic [11:0] t_ckesr, t_cksre, t_cksrx, t_xs, t_xsdll, t_zqoper;
  logic [11:0] cnt, dll_cnt, vref_cnt;
  logic        enter_req, exit_req, stop_clk, auto_sel, range_sel, hot, vfloat, odt_used;
  logic        write_ok, locked_ok, deferred;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      t_ckesr  <= dsrs_pkg::DEF_CKESR;
      t_cksre  <= dsrs_pkg::DEF_CKSRE;
      t_cksrx  <= dsrs_pkg::DEF_CKSRX;
      t_xs     <= dsrs_pkg::DEF_XS;
      t_xsdll  <= dsrs_pkg::DEF_XSDLL;
      t_zqoper <= dsrs_pkg::DEF_ZQOPER;
      stop_clk <= 1'b0;
      auto_sel <= 1'b0;
      range_sel <= 1'b0;
      hot      <= 1'b0;
      vfloat   <= 1'b0;
      odt_used <= 1'b0;
    end else if (wr) begin
      if (hit(addr, dsrs_pkg::REG_CTRL)) begin
        stop_clk  <= wdata[dsrs_pkg::CTRL_STOPCLK];
        auto_sel  <= wdata[dsrs_pkg::CTRL_AUTO];
        // Range is forced off when automatic mode is chosen.
        range_sel <= wdata[dsrs_pkg::CTRL_RANGE] && !wdata[dsrs_pkg::CTRL_AUTO];
        hot       <= wdata[dsrs_pkg::CTRL_HOT];
        vfloat    <= wdata[dsrs_pkg::CTRL_VFLOAT];
        odt_used  <= wdata[dsrs_pkg::CTRL_ODT_USED];
      end else if (hit(addr, dsrs_pkg::REG_CKESR)) begin
        t_ckesr <= wdata[11:0];
      end else if (hit(addr, dsrs_pkg::REG_CKSRE)) begin
        t_cksre <= wdata[11:0];
      end else if (hit(addr, dsrs_pkg::REG_CKSRX)) begin
        t_cksrx <= wdata[11:0];
      end else if (hit(addr, dsrs_pkg::REG_XS)) begin
        t_xs <= wdata[11:0];
      end else if (hit(addr, dsrs_pkg::REG_XSDLL)) begin
        t_xsdll <= wdata[11:0];
      end else if (hit(addr, dsrs_pkg::REG_ZQOPER)) begin
        t_zqoper <= wdata[11:0];
      end
    end
  end

  wire ctrl_wr = wr && hit(addr, dsrs_pkg::REG_CTRL);
  wire may_enter = bank_idle && (!hot || auto_sel || range_sel);

  // Requests are sticky pulses; a new write wins over the consuming clear.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      enter_req <= 1'b0;
      exit_req  <= 1'b0;
    end else begin
      if (ctrl_wr && wdata[dsrs_pkg::CTRL_ENTER]) begin
        enter_req <= 1'b1;
      end else if (state == dsrs_pkg::DSRS_C_ENTER) begin
        enter_req <= 1'b0;
      end
      if (ctrl_wr && wdata[dsrs_pkg::CTRL_EXIT]) begin
        exit_req <= 1'b1;
      end else if (state == dsrs_pkg::DSRS_C_XS) begin
        exit_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state        <= dsrs_pkg::DSRS_C_IDLE;
      cnt          <= 12'h000;
      link.cke     <= 1'b1;
      link.cmd     <= dsrs_pkg::CMD_NOP;
      link.clk_run <= 1'b1;
    end else begin
      link.cmd <= dsrs_pkg::CMD_NOP;
      if (cnt != 12'h000) begin
        cnt <= cnt - 12'h001;
      end
      case (state)
        dsrs_pkg::DSRS_C_IDLE, dsrs_pkg::DSRS_C_READY: begin
          if (enter_req && may_enter && !link.odt) begin
            link.cke <= 1'b0;
            link.cmd <= dsrs_pkg::CMD_REFRESH;
            cnt      <= stop_clk ? t_cksre : t_ckesr;
            state    <= dsrs_pkg::DSRS_C_ENTER;
          end
        end
        dsrs_pkg::DSRS_C_ENTER: begin
          if (cnt == 12'h000) begin
            if (stop_clk) begin
              link.clk_run <= 1'b0;
            end
            state <= dsrs_pkg::DSRS_C_IN;
          end
        end
        dsrs_pkg::DSRS_C_IN: begin
          link.cke <= 1'b0;
          if (!link.clk_run && exit_req) begin
            link.clk_run <= 1'b1;
            cnt          <= t_cksrx;
          end else if (link.clk_run && exit_req && cnt == 12'h000) begin
            link.cke <= 1'b1;
            cnt      <= t_xs;
            state    <= dsrs_pkg::DSRS_C_XS;
          end
        end
        dsrs_pkg::DSRS_C_XS: begin
          if (cnt == 12'h000) begin
            link.cmd <= dsrs_pkg::CMD_ZQCL;
            cnt      <= t_zqoper;
            state    <= dsrs_pkg::DSRS_C_ZQ;
          end
        end
        dsrs_pkg::DSRS_C_ZQ: begin
          if (cnt == 12'h000 && dll_cnt == 12'h000) begin
            state <= dsrs_pkg::DSRS_C_READY;
          end
        end
        default: state <= dsrs_pkg::DSRS_C_IDLE;
      endcase
    end
  end

  // The DLL window counts from the edge where CKE high is registered.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dll_cnt  <= 12'h000;
      vref_cnt <= 12'h000;
    end else if (state == dsrs_pkg::DSRS_C_IN && link.clk_run && exit_req && cnt == 12'h000) begin
      dll_cnt  <= t_xsdll;
      vref_cnt <= vfloat ? dsrs_pkg::VREF_WRITE_WAIT : 12'h000;
    end else begin
      if (dll_cnt != 12'h000) begin
        dll_cnt <= dll_cnt - 12'h001;
      end
      if (vref_cnt != 12'h000) begin
        vref_cnt <= vref_cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      link.odt     <= 1'b0;
      link.reset_n <= 1'b1;
      link.mr2     <= 8'h00;
      ref_fast     <= 1'b0;
      write_ok     <= 1'b1;
      locked_ok    <= 1'b1;
    end else begin
      link.odt <= odt_used && state == dsrs_pkg::DSRS_C_IDLE && !enter_req;
      link.mr2 <= {range_sel, auto_sel, 6'h00};
      ref_fast <= hot;
      write_ok <= (state == dsrs_pkg::DSRS_C_IDLE || state == dsrs_pkg::DSRS_C_READY)
                  && vref_cnt == 12'h000;
      locked_ok <= state == dsrs_pkg::DSRS_C_IDLE || state == dsrs_pkg::DSRS_C_READY;
    end
  end

  assign deferred = enter_req && !may_enter;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      if (hit(addr, dsrs_pkg::REG_STATUS)) begin
        rdata <= {8'h00, deferred, locked_ok, write_ok, link.cke, link.clk_run, state};
      end else if (hit(addr, dsrs_pkg::REG_CTRL)) begin
        rdata <= {8'h00, odt_used, vfloat, hot, range_sel, auto_sel, stop_clk,
                  exit_req, enter_req};
      end else if (hit(addr, dsrs_pkg::REG_CKESR)) begin
        rdata <= {4'h0, t_ckesr};
      end else if (hit(addr, dsrs_pkg::REG_CKSRE)) begin
        rdata <= {4'h0, t_cksre};
      end else if (hit(addr, dsrs_pkg::REG_CKSRX)) begin
        rdata <= {4'h0, t_cksrx};
      end else if (hit(addr, dsrs_pkg::REG_XS)) begin
        rdata <= {4'h0, t_xs};
      end else if (hit(addr, dsrs_pkg::REG_XSDLL)) begin
        rdata <= {4'h0, t_xsdll};
      end else if (hit(addr, dsrs_pkg::REG_ZQOPER)) begin
        rdata <= {4'h0, t_zqoper};
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule // dsrs_ctl
`default_nettype wire

// ===== rtl/dsrs_device.sv
`default_nettype none
module dsrs_device (
  input  wire logic sys_clk,       // Memory clock.
  input  wire logic nrst,          // Asynchronous reset, active low.
  dsrs_if.dev       link,          // Pins from the controller.
  output logic      in_self_ref,   // Device is in self refresh.
  output logic      dll_enable,    // DLL enabled.
  output logic      dll_reset,     // One-cycle DLL reset pulse.
  output logic      int_refresh,   // One-cycle internal refresh pulse.
  output logic      auto_rate,     // Rate follows temperature automatically.
  output logic      ext_range      // Manual extended range in force.
);
  logic [11:0] ref_cnt;
  logic        cke_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      in_self_ref <= 1'b0;
      cke_q       <= 1'b1;
    end else if (!link.reset_n) begin
      in_self_ref <= 1'b0;
      cke_q       <= 1'b1;
    end else begin
      cke_q <= link.cke;
      if (!in_self_ref && !link.cke && cke_q && link.cmd == dsrs_pkg::CMD_REFRESH) begin
        in_self_ref <= 1'b1;
      end else if (in_self_ref && link.cke) begin
        in_self_ref <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dll_enable <= 1'b1;
      dll_reset  <= 1'b0;
    end else begin
      dll_reset <= 1'b0;
      if (!in_self_ref && !link.cke && cke_q && link.cmd == dsrs_pkg::CMD_REFRESH) begin
        dll_enable <= 1'b0;
      end else if (in_self_ref && link.cke) begin
        dll_enable <= 1'b1;
        dll_reset  <= 1'b1;
      end
    end
  end

  // The first internal refresh fires inside the CKE period; later ones repeat on that count.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_cnt     <= 12'h000;
      int_refresh <= 1'b0;
    end else if (!in_self_ref) begin
      ref_cnt     <= 12'h000;
      int_refresh <= 1'b0;
    end else if (ref_cnt == dsrs_pkg::CKE_PERIOD - 12'h001) begin
      ref_cnt     <= 12'h000;
      int_refresh <= 1'b1;
    end else begin
      ref_cnt     <= ref_cnt + 12'h001;
      int_refresh <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      auto_rate <= 1'b0;
      ext_range <= 1'b0;
    end else begin
      auto_rate <= link.mr2[dsrs_pkg::MR2_AUTO_BIT];
      ext_range <= !link.mr2[dsrs_pkg::MR2_AUTO_BIT] && link.mr2[dsrs_pkg::MR2_RANGE_BIT];
    end
  end
endmodule // dsrs_device
`default_nettype wire

// ===== sim/dsrs_assertions.sv
`default_nettype none
module dsrs_assertions (
  input wire logic       sys_clk,     // Memory clock.
  input wire logic       nrst,        // Reset, active low.
  input wire logic       cke,         // Clock enable.
  input wire logic [3:0] cmd,         // Command code.
  input wire logic       odt,         // Termination enable.
  input wire logic       clk_run,     // Memory clock running.
  input wire logic [7:0] mr2,         // Mode register 2.
  input wire logic       in_self_ref, // Device in self refresh.
  input wire logic       dll_enable,  // Device DLL on.
  input wire logic       dll_reset,   // Device DLL reset pulse.
  input wire logic       int_refresh, // Device internal refresh.
  input wire logic       auto_rate,   // Automatic rate in force.
  input wire logic       ext_range    // Extended range in force.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_entry;
    $fell(cke) && cmd == dsrs_pkg::CMD_REFRESH;
  endsequence
  sequence s_quiet;
    cmd == dsrs_pkg::CMD_NOP || cmd == dsrs_pkg::CMD_DES;
  endsequence
  entry_command_a: assert property ($fell(cke) |-> cmd == dsrs_pkg::CMD_REFRESH && !odt)
    else $error("entry without refresh command or with termination on");
  after_entry_nop_a: assert property (s_entry |=> s_quiet)
    else $error("no idle command after entry");
  hold_quiet_a: assert property (!cke && !$fell(cke) |-> s_quiet)
    else $error("command issued while clock enable low");
  dll_off_a: assert property (s_entry |=> in_self_ref && !dll_enable)
    else $error("device did not enter self refresh with DLL off");
  exit_dll_a: assert property ($rose(cke) && in_self_ref |-> ##[0:2] dll_reset ##[0:2] dll_enable)
    else $error("DLL not reset and enabled on exit");
  low_min_a: assert property ($fell(cke) |-> !cke [*5])
    else $error("clock enable raised before minimum low time");
  exit_quiet_a: assert property ($rose(cke) && in_self_ref |-> s_quiet [*8])
    else $error("command issued during exit interval");
  clk_stop_a: assert property ($fell(clk_run) |-> !cke && $past(cke, 5) == 1'b0)
    else $error("clock stopped too early after entry");
  clk_restart_a: assert property ($rose(clk_run) |-> !cke [*5])
    else $error("exit too soon after clock restart");
  mode_bits_a: assert property (mr2[dsrs_pkg::MR2_AUTO_BIT] |-> !mr2[dsrs_pkg::MR2_RANGE_BIT])
    else $error("automatic and range bits both set");
  rate_follow_a: assert property (mr2[dsrs_pkg::MR2_AUTO_BIT] |=> auto_rate && !ext_range)
    else $error("device rate mode does not follow mode register");
  int_refresh_a: assert property ($rose(in_self_ref) |-> ##[0:3] int_refresh)
    else $error("no internal refresh after entry");
  zq_odt_a: assert property (cmd == dsrs_pkg::CMD_ZQCL |-> !odt)
    else $error("termination on during calibration");
endmodule // dsrs_assertions
`default_nettype wire

// ===== sim/dsrs_test.sv
`default_nettype none
module dsrs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ENTER = 16'h0001 << dsrs_pkg::CTRL_ENTER;
  localparam logic [15:0] EXIT = 16'h0001 << dsrs_pkg::CTRL_EXIT;
  localparam logic [15:0] STOP = 16'h0001 << dsrs_pkg::CTRL_STOPCLK;
  localparam logic [15:0] AUTO = 16'h0001 << dsrs_pkg::CTRL_AUTO;
  localparam logic [15:0] HOT = 16'h0001 << dsrs_pkg::CTRL_HOT;
  localparam logic [15:0] ODTU = 16'h0001 << dsrs_pkg::CTRL_ODT_USED;
  localparam logic [15:0] VFLT = 16'h0001 << dsrs_pkg::CTRL_VFLOAT;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        bank_idle = 1'b1;
  logic [15:0] rdata;
  logic [15:0] v;
  logic        ref_fast, in_self_ref, dll_enable, dll_reset, int_refresh, auto_rate, ext_range;
  int          err_count = 0;
  int          compares = 0;
  dsrs_if dsrs_if_i ();
  dsrs_ctl dsrs_ctl_i (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .bank_idle(bank_idle), .rdata(rdata), .ref_fast(ref_fast), .link(dsrs_if_i.ctl));
  dsrs_device dsrs_device_i (.sys_clk(sys_clk), .nrst(nrst), .link(dsrs_if_i.dev),
    .in_self_ref(in_self_ref), .dll_enable(dll_enable), .dll_reset(dll_reset),
    .int_refresh(int_refresh), .auto_rate(auto_rate), .ext_range(ext_range));
  dsrs_assertions dsrs_assertions_i (.sys_clk(sys_clk), .nrst(nrst), .cke(dsrs_if_i.cke),
    .cmd(dsrs_if_i.cmd), .odt(dsrs_if_i.odt), .clk_run(dsrs_if_i.clk_run), .mr2(dsrs_if_i.mr2),
    .in_self_ref(in_self_ref), .dll_enable(dll_enable), .dll_reset(dll_reset),
    .int_refresh(int_refresh), .auto_rate(auto_rate), .ext_range(ext_range));
  always #12.5 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 1000; i++) begin
      reg_rd(dsrs_pkg::REG_STATUS);
      if (v[2:0] === s) break;
    end
    check("state", {13'h0000, v[2:0]}, {13'h0000, s});
  endtask
  task automatic t_regs();
    logic [11:0] dflt [6];
    dflt = '{dsrs_pkg::DEF_CKESR, dsrs_pkg::DEF_CKSRE, dsrs_pkg::DEF_CKSRX,
             dsrs_pkg::DEF_XS, dsrs_pkg::DEF_XSDLL, dsrs_pkg::DEF_ZQOPER};
    for (int i = 0; i < 6; i++) begin
      reg_rd(dsrs_pkg::REG_CKESR + 4'(i));
      check("timer default", v, {4'h0, dflt[i]});
    end
    reg_wr(dsrs_pkg::REG_XS, 16'h0012);
    reg_rd(dsrs_pkg::REG_XS);
    check("timer write", v, 16'h0012);
    reg_wr(dsrs_pkg::REG_XS, {4'h0, dsrs_pkg::DEF_XS});
    reg_rd(4'hf);
    check("unmapped", v, 16'h0000);
    $display("done t_regs");
  endtask
  task automatic t_cycle(input logic [15:0] mode);
    if ((mode & ODTU) != 16'h0000) begin
      reg_wr(dsrs_pkg::REG_CTRL, mode);
      @(posedge sys_clk);
      #1 check("odt idle", dsrs_if_i.odt, 16'h0001);
    end
    reg_wr(dsrs_pkg::REG_CTRL, mode | ENTER);
    wait_state(dsrs_pkg::DSRS_C_IN);
    check("odt off", dsrs_if_i.odt, 16'h0000);
    check("dll off", dll_enable, 16'h0000);
    check("cke low", dsrs_if_i.cke, 16'h0000);
    repeat (20) @(posedge sys_clk);
    check("clock run", dsrs_if_i.clk_run, (mode & STOP) ? 16'h0000 : 16'h0001);
    reg_wr(dsrs_pkg::REG_CTRL, mode | EXIT);
    wait_state(dsrs_pkg::DSRS_C_READY);
    check("dll on", dll_enable, 16'h0001);
    check("out of sr", in_self_ref, 16'h0000);
    reg_rd(dsrs_pkg::REG_STATUS);
    check("locked", v[6], 16'h0001);
    check("write ok", v[5], 16'h0001);
    $display("done t_cycle %h", mode);
  endtask
  task automatic t_hot();
    reg_wr(dsrs_pkg::REG_CTRL, HOT | ENTER);
    repeat (10) @(posedge sys_clk);
    reg_rd(dsrs_pkg::REG_STATUS);
    check("deferred", v[7], 16'h0001);
    check("cke held", dsrs_if_i.cke, 16'h0001);
    check("fast refresh", ref_fast, 16'h0001);
    t_cycle(HOT | AUTO | (16'h0001 << dsrs_pkg::CTRL_RANGE));
    check("mr2 auto", dsrs_if_i.mr2, 16'h0040);
    check("auto rate", auto_rate, 16'h0001);
    reg_wr(dsrs_pkg::REG_CTRL, 16'h0001 << dsrs_pkg::CTRL_RANGE);
    repeat (4) @(posedge sys_clk);
    check("mr2 range", dsrs_if_i.mr2, 16'h0080);
    check("ext range", ext_range, 16'h0001);
    $display("done t_hot");
  endtask
  task automatic t_busy();
    bank_idle <= 1'b0;
    reg_wr(dsrs_pkg::REG_CTRL, ENTER);
    repeat (10) @(posedge sys_clk);
    check("busy cke", dsrs_if_i.cke, 16'h0001);
    bank_idle <= 1'b1;
    wait_state(dsrs_pkg::DSRS_C_IN);
    reg_wr(dsrs_pkg::REG_CTRL, EXIT);
    wait_state(dsrs_pkg::DSRS_C_READY);
    $display("done t_busy");
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    check("reset cke", dsrs_if_i.cke, 16'h0001);
    check("reset cmd", dsrs_if_i.cmd, {12'h000, dsrs_pkg::CMD_NOP});
    t_regs();
    t_cycle(ODTU | VFLT);
    t_cycle(STOP);
    t_hot();
    t_busy();
    wrap_up();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end
endmodule // dsrs_test
`default_nettype wire
